// [hdl/eau_defs.svh]
// Constants for the external access unit: encodings, field positions, reset values.
// Assumes it is included by bare name from the package and the design modules.
`ifndef EAU_DEFS_SVH
`define EAU_DEFS_SVH

`define EAU_NUM_REGIONS 5
`define EAU_DEFAULT_SET 3'h5
`define EAU_NUM_SETS 6

// Timing set layout
`define EAU_TIM_WAIT_MSB 3
`define EAU_TIM_WAIT_LSB 0
`define EAU_TIM_TRI 4
`define EAU_TIM_ALE_LONG 5
`define EAU_TIM_RW_DELAY 6
`define EAU_TIM_READY_EN 7
// Slowest: 15 waits, tri-state cycle, long address phase, read/write delay
`define EAU_TIM_SLOW 8'h7f

// Bus modes
`define EAU_MODE_SINGLE 3'h0
`define EAU_MODE_DMX16 3'h1
`define EAU_MODE_MUX16 3'h2
`define EAU_MODE_MUX8 3'h3
`define EAU_MODE_DMX8 3'h4

// Address space sizes
`define EAU_SPACE_64K 2'h0
`define EAU_SPACE_256K 2'h1
`define EAU_SPACE_1M 2'h2
`define EAU_SPACE_16M 2'h3
`define EAU_UPPER_64K 8'hff
`define EAU_UPPER_256K 8'hfc
`define EAU_UPPER_1M 8'hf0
`define EAU_UPPER_16M 8'h00

// Two internal register areas of 512 bytes each
`define EAU_SFR_BASE 24'h00fe00
`define EAU_ESFR_BASE 24'h00f000
`define EAU_SFR_HI_MSB 23
`define EAU_SFR_HI_LSB 9

// Port 6 bit positions
`define EAU_P6_HOLD 5
`define EAU_P6_GRANT 6
`define EAU_P6_REGAIN 7

`endif

// [hdl/eau_pkg.sv]
// Types shared by the external access unit modules.
// Assumes eau_defs.svh is on the include path.
`include "eau_defs.svh"

package eau_pkg;

    typedef enum logic [5:0] {
        EAU_IDLE = 6'h01,
        EAU_ADDR = 6'h02,
        EAU_DELAY = 6'h04,
        EAU_STROBE = 6'h08,
        EAU_TRI = 6'h10,
        EAU_HOLD = 6'h20
    } eau_state_e;

    typedef logic [2:0] eau_mode_t;
    typedef logic [1:0] eau_space_t;
    typedef logic [7:0] eau_timing_t;

endpackage

// [hdl/eau_region_match.sv]
// One address window comparator for a chip-select region.
// Assumes address bits 23..12 compared under a mask; purely combinational.
`timescale 1ns/1ps

module eau_region_match
    import eau_pkg::*;
(
    input wire logic [11:0] addrHigh,
    input wire logic [11:0] base,
    input wire logic [11:0] mask,
    input wire logic enable,
    output logic hit
);
    // Mask bit set means the address bit is compared
    assign hit = enable && (((addrHigh ^ base) & mask) == 12'h000);
endmodule

// [hdl/eau_external_access_unit.sv]
// External access unit: sequences every external memory access over the pins.
// Assumes a core that holds reqValid until respDone, and synchronous pin inputs.
//
// Functional notes
// - Single-chip mode answers requests without touching the external bus.
// - Four external modes: 8/16-bit data, muxed or demuxed, four address widths.
// - Demuxed: address on address-only port, data both ways on shared port.
// - Muxed: shared port carries address first, then data.
// - Wait states, tri-state cycle, long address phase, read/write delay programmable.
// - Each address region uses its own timing set, chosen per access.
// - Up to five active-low region selects decoded from the address.
// - Region selects 0 to 4 appear on port 6 bits 0 to 4.
// - Ready input stretches accesses for slow devices, which signal not-ready.
// - Hold request on bit 5, grant on bit 6, regain request on bit 7.
// - 1M, 256K, 64K spaces drive four, two, zero upper address lines.
// - Full 16M space drives all eight upper address lines.
// - One linear 16M space, byte or word access anywhere.
// - All external accesses go through this unit, 24-bit address reach.
// - Each port 6 output individually push-pull or open-drain.
// - With ready enabled, ready high adds waits until it returns low.
// - Muxed modes pulse the address latch output during address phase.
// - Read strobe active for every external read.
// - Store pin strobes every write, or every write except odd-address byte writes on a 16-bit bus.
`timescale 1ns/1ps
`include "eau_defs.svh"

module eau_external_access_unit
    import eau_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] bootMode,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqByte,
    input wire logic [23:0] reqAddr,
    input wire logic [15:0] reqWdata,
    output logic respDone,
    output logic [15:0] respRdata,
    input wire logic cfgLoad,
    input wire logic [2:0] cfgBusMode,
    input wire logic [1:0] cfgSpace,
    input wire logic storePinConfig,
    input wire logic [47:0] cfgTiming,
    input wire logic [59:0] regionBase,
    input wire logic [59:0] regionMask,
    input wire logic [4:0] regionEnable,
    input wire logic [7:0] p6OpenDrain,
    output logic [2:0] busModeNow,
    input wire logic [15:0] sharedBusPortIn,
    output logic [15:0] sharedBusPortOut,
    output logic [15:0] sharedBusPortOeN,
    output logic [15:0] addressOnlyPortOut,
    output logic [15:0] addressOnlyPortOeN,
    output logic [7:0] upperAddrOut,
    output logic [7:0] upperAddrOeN,
    output logic addrLatch,
    output logic readStrobeN,
    output logic storeStrobeN,
    output logic strobeOeN,
    input wire logic readyPin,
    input wire logic [7:0] p6In,
    output logic [7:0] p6Out,
    output logic [7:0] p6OeN
);
    eau_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [23:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic write_reg, write_next, byte_reg, byte_next, second_reg, second_next;
    logic done_reg, done_next;
    eau_timing_t set_reg, set_next;
    logic [4:0] cs_reg, cs_next;
    eau_mode_t mode_reg, mode_next;
    eau_space_t space_reg, space_next;
    logic wrl_reg, wrl_next;
    eau_timing_t timing_reg [0:5];
    eau_timing_t timing_next [0:5];
    logic [15:0] shOut_reg, shOut_next, shOe_reg, shOe_next;
    logic [15:0] aoOut_reg, aoOut_next, aoOe_reg, aoOe_next;
    logic [7:0] upOut_reg, upOut_next, upOe_reg, upOe_next;
    logic ale_reg, ale_next, rdN_reg, rdN_next, stN_reg, stN_next, stOe_reg, stOe_next;
    logic [7:0] p6Out_reg, p6Out_next, p6Oe_reg, p6Oe_next;
    logic [4:0] hits;
    logic [2:0] setSel;
    logic sfrHit, isMux, isDmx, is8, active, finish, holdReq;
    logic [7:0] p6Val;
    logic [15:0] dataWord;

    ////////////////////////////////////////////////////////////////////////
    // Region decode
    genvar gi;
    generate
        for (gi = 0; gi < `EAU_NUM_REGIONS; gi = gi + 1) begin : g_region
            eau_region_match u_match (
                .addrHigh(reqAddr[23:12]),
                .base(regionBase[gi*12 +: 12]),
                .mask(regionMask[gi*12 +: 12]),
                .enable(regionEnable[gi]),
                .hit(hits[gi])
            );
        end
    endgenerate

    // Lowest region wins on overlap
    always_comb begin
        setSel = `EAU_DEFAULT_SET;
        for (int i = `EAU_NUM_REGIONS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                setSel = 3'(i);
            end
        end
    end

    assign sfrHit = (reqAddr[`EAU_SFR_HI_MSB:`EAU_SFR_HI_LSB] == 15'(`EAU_SFR_BASE >> 9))
        || (reqAddr[`EAU_SFR_HI_MSB:`EAU_SFR_HI_LSB] == 15'(`EAU_ESFR_BASE >> 9));
    assign holdReq = !p6In[`EAU_P6_HOLD];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and pin image
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        write_next = write_reg;
        byte_next = byte_reg;
        second_next = second_reg;
        set_next = set_reg;
        cs_next = cs_reg;
        mode_next = mode_reg;
        space_next = space_reg;
        wrl_next = wrl_reg;
        timing_next = timing_reg;
        done_next = 1'b0;
        finish = 1'b0;
        isMux = (mode_reg == `EAU_MODE_MUX16) || (mode_reg == `EAU_MODE_MUX8);
        isDmx = (mode_reg == `EAU_MODE_DMX16) || (mode_reg == `EAU_MODE_DMX8);
        is8 = (mode_reg == `EAU_MODE_MUX8) || (mode_reg == `EAU_MODE_DMX8);
        case (state_reg)
            EAU_IDLE: begin
                // Config changes only between accesses, never mid-cycle
                if (cfgLoad) begin
                    mode_next = cfgBusMode;
                    space_next = cfgSpace;
                    wrl_next = storePinConfig;
                    for (int i = 0; i < `EAU_NUM_SETS; i++) begin
                        timing_next[i] = cfgTiming[i*8 +: 8];
                    end
                end else if (holdReq) begin
                    state_next = EAU_HOLD;
                end else if (reqValid && !done_reg) begin
                    addr_next = reqAddr;
                    wdata_next = reqWdata;
                    write_next = reqWrite;
                    byte_next = reqByte;
                    second_next = 1'b0;
                    rdata_next = 16'h0000;
                    if (mode_reg == `EAU_MODE_SINGLE || sfrHit) begin
                        done_next = 1'b1;
                    end else begin
                        set_next = timing_reg[setSel];
                        cs_next = ~hits;
                        cnt_next = {3'h0, timing_reg[setSel][`EAU_TIM_ALE_LONG]};
                        state_next = EAU_ADDR;
                    end
                end
            end
            EAU_ADDR: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (set_reg[`EAU_TIM_RW_DELAY]) begin
                    state_next = EAU_DELAY;
                end else begin
                    state_next = EAU_STROBE;
                    cnt_next = set_reg[`EAU_TIM_WAIT_MSB:`EAU_TIM_WAIT_LSB];
                end
            end
            EAU_DELAY: begin
                state_next = EAU_STROBE;
                cnt_next = set_reg[`EAU_TIM_WAIT_MSB:`EAU_TIM_WAIT_LSB];
            end
            EAU_STROBE: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (!(set_reg[`EAU_TIM_READY_EN] && readyPin)) begin
                    if (!write_reg) begin
                        if (is8 && second_reg) begin
                            rdata_next[15:8] = sharedBusPortIn[7:0];
                        end else if (is8 || (byte_reg && !addr_reg[0])) begin
                            rdata_next[7:0] = sharedBusPortIn[7:0];
                        end else if (byte_reg) begin
                            rdata_next[7:0] = sharedBusPortIn[15:8];
                        end else begin
                            rdata_next = sharedBusPortIn;
                        end
                    end
                    if (set_reg[`EAU_TIM_TRI]) begin
                        state_next = EAU_TRI;
                    end else begin
                        finish = 1'b1;
                    end
                end
            end
            EAU_TRI: finish = 1'b1;
            EAU_HOLD: begin
                if (!holdReq) begin
                    state_next = EAU_IDLE;
                end
            end
            default: state_next = EAU_IDLE;
        endcase
        if (finish) begin
            // Word on an 8-bit bus takes a second byte cycle
            if (is8 && !byte_reg && !second_reg) begin
                second_next = 1'b1;
                addr_next = addr_reg + 24'h000001;
                cnt_next = {3'h0, set_reg[`EAU_TIM_ALE_LONG]};
                state_next = EAU_ADDR;
            end else begin
                done_next = 1'b1;
                cs_next = 5'h1f;
                state_next = EAU_IDLE;
            end
        end

        active = (state_next == EAU_ADDR) || (state_next == EAU_DELAY)
            || (state_next == EAU_STROBE) || (state_next == EAU_TRI);
        if (is8) begin
            dataWord = {8'h00, second_next ? wdata_next[15:8] : wdata_next[7:0]};
        end else if (byte_next) begin
            dataWord = {wdata_next[7:0], wdata_next[7:0]};
        end else begin
            dataWord = wdata_next;
        end
        shOut_next = 16'h0000;
        shOe_next = 16'hffff;
        if (state_next == EAU_ADDR && isMux) begin
            shOut_next = addr_next[15:0];
            shOe_next = 16'h0000;
        end else if (state_next == EAU_DELAY || state_next == EAU_STROBE) begin
            if (write_next) begin
                shOut_next = dataWord;
                shOe_next = is8 ? 16'hff00 : 16'h0000;
            end
            if (mode_reg == `EAU_MODE_MUX8) begin
                shOut_next[15:8] = addr_next[15:8];
                shOe_next[15:8] = 8'h00;
            end
        end
        aoOut_next = active && isDmx ? addr_next[15:0] : 16'h0000;
        aoOe_next = active && isDmx ? 16'h0000 : 16'hffff;
        upOut_next = active ? addr_next[23:16] : 8'h00;
        case (space_reg)
            `EAU_SPACE_64K: upOe_next = `EAU_UPPER_64K;
            `EAU_SPACE_256K: upOe_next = `EAU_UPPER_256K;
            `EAU_SPACE_1M: upOe_next = `EAU_UPPER_1M;
            default: upOe_next = `EAU_UPPER_16M;
        endcase
        if (!active) begin
            upOe_next = 8'hff;
        end
        ale_next = (state_next == EAU_ADDR) && isMux;
        rdN_next = !(state_next == EAU_STROBE && !write_next);
        stN_next = !(state_next == EAU_STROBE && write_next
            && (!wrl_reg || is8 || !byte_next || !addr_next[0]));
        stOe_next = (state_next == EAU_HOLD);
        p6Val = {!(state_next == EAU_HOLD && reqValid), !(state_next == EAU_HOLD), 1'b1, cs_next};
        for (int i = 0; i < 8; i++) begin
            p6Out_next[i] = p6OpenDrain[i] ? 1'b0 : p6Val[i];
            p6Oe_next[i] = p6OpenDrain[i] ? p6Val[i] : 1'b0;
        end
        p6Oe_next[`EAU_P6_HOLD] = 1'b1;
        if (state_next == EAU_HOLD) begin
            p6Oe_next[4:0] = 5'h1f;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= EAU_IDLE;
            cnt_reg <= 4'h0;
            addr_reg <= 24'h000000;
            wdata_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            write_reg <= 1'b0;
            byte_reg <= 1'b0;
            second_reg <= 1'b0;
            done_reg <= 1'b0;
            set_reg <= `EAU_TIM_SLOW;
            cs_reg <= 5'h1f;
            mode_reg <= bootMode;
            space_reg <= `EAU_SPACE_16M;
            wrl_reg <= 1'b0;
            for (int i = 0; i < `EAU_NUM_SETS; i++) begin
                timing_reg[i] <= `EAU_TIM_SLOW;
            end
            shOut_reg <= 16'h0000;
            shOe_reg <= 16'hffff;
            aoOut_reg <= 16'h0000;
            aoOe_reg <= 16'hffff;
            upOut_reg <= 8'h00;
            upOe_reg <= 8'hff;
            ale_reg <= 1'b0;
            rdN_reg <= 1'b1;
            stN_reg <= 1'b1;
            stOe_reg <= 1'b0;
            p6Out_reg <= 8'h00;
            p6Oe_reg <= 8'hff;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            write_reg <= write_next;
            byte_reg <= byte_next;
            second_reg <= second_next;
            done_reg <= done_next;
            set_reg <= set_next;
            cs_reg <= cs_next;
            mode_reg <= mode_next;
            space_reg <= space_next;
            wrl_reg <= wrl_next;
            timing_reg <= timing_next;
            shOut_reg <= shOut_next;
            shOe_reg <= shOe_next;
            aoOut_reg <= aoOut_next;
            aoOe_reg <= aoOe_next;
            upOut_reg <= upOut_next;
            upOe_reg <= upOe_next;
            ale_reg <= ale_next;
            rdN_reg <= rdN_next;
            stN_reg <= stN_next;
            stOe_reg <= stOe_next;
            p6Out_reg <= p6Out_next;
            p6Oe_reg <= p6Oe_next;
        end
    end

    assign respDone = done_reg;
    assign respRdata = rdata_reg;
    assign busModeNow = mode_reg;
    assign sharedBusPortOut = shOut_reg;
    assign sharedBusPortOeN = shOe_reg;
    assign addressOnlyPortOut = aoOut_reg;
    assign addressOnlyPortOeN = aoOe_reg;
    assign upperAddrOut = upOut_reg;
    assign upperAddrOeN = upOe_reg;
    assign addrLatch = ale_reg;
    assign readStrobeN = rdN_reg;
    assign storeStrobeN = stN_reg;
    assign strobeOeN = stOe_reg;
    assign p6Out = p6Out_reg;
    assign p6OeN = p6Oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_single_quiet: assert property (mode_reg == `EAU_MODE_SINGLE |-> readStrobeN && storeStrobeN && !addrLatch)
        else $error("external strobe in single-chip mode");
    chk_hold_float: assert property (state_reg == EAU_HOLD |-> sharedBusPortOeN == 16'hffff && strobeOeN
        && p6OeN[4:0] == 5'h1f) else $error("bus not floated while granted");
    chk_ale_mux: assert property (addrLatch |-> isMux && sharedBusPortOeN == 16'h0000)
        else $error("address latch outside muxed address phase");
    chk_demux_addr: assert property (!readStrobeN && isDmx |-> addressOnlyPortOeN == 16'h0000
        && addressOnlyPortOut == addr_reg[15:0]) else $error("demuxed address not driven");
    chk_ready_wait: assert property (state_reg == EAU_STROBE && cnt_reg == 4'h0 && set_reg[`EAU_TIM_READY_EN]
        && readyPin |=> state_reg == EAU_STROBE && $stable(addr_reg)) else $error("ready ignored");
    chk_cs_onehot: assert property ($onehot0(~cs_reg)) else $error("more than one region select");
    chk_upper_lines: assert property (!readStrobeN && space_reg == `EAU_SPACE_64K |-> upperAddrOeN == 8'hff)
        else $error("upper lines driven in 64K space");
    chk_upper_full: assert property (!readStrobeN && space_reg == `EAU_SPACE_16M
        |-> upperAddrOeN == 8'h00 && upperAddrOut == addr_reg[23:16]) else $error("upper lines missing");
    chk_hold_grant: assert property (state_reg == EAU_IDLE && holdReq && !cfgLoad |=> state_reg == EAU_HOLD
        && !p6Oe_reg[`EAU_P6_GRANT] && !p6Out_reg[`EAU_P6_GRANT]) else $error("hold not granted");
    chk_wrl_high: assert property (!stN_reg |-> write_reg && (!wrl_reg || is8 || !byte_reg || !addr_reg[0]))
        else $error("store strobe on high byte in low-byte mode");
endmodule

// [testbench/eau_ext_mem.sv]
// Behavioural external memory on the far side of the access unit.
// Assumes registered strobes from the unit; bus widths follow its mode.
`timescale 1ns/1ps

module eau_ext_mem (
    input wire logic clock,
    input wire logic muxed,
    input wire logic wide,
    input wire logic slow,
    input wire logic [15:0] busOut,
    input wire logic [15:0] addrOut,
    input wire logic addrLatch,
    input wire logic readStrobeN,
    input wire logic storeStrobeN,
    output logic [15:0] busIn,
    output logic readyPin,
    output int rdCount,
    output int wrCount,
    output logic [15:0] lastWr
);
    logic [7:0] latched = 8'h00;
    logic [7:0] a;
    logic [15:0] held = 16'h0000;
    int stall = 0;

    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [7:0] x);
        return x ^ 8'h5a;
    endfunction

    assign a = muxed ? latched : addrOut[7:0];
    // Released bus toggles every cycle so a late sample never matches
    assign busIn = !readStrobeN ? (wide ? {pat(a | 8'h01), pat(a & 8'hfe)} : {~held[15:8], pat(a)}) : ~held;
    // Slow device: not ready for three strobe cycles
    assign readyPin = slow && !(readStrobeN && storeStrobeN) && stall < 3;

    initial begin
        rdCount = 0;
        wrCount = 0;
        lastWr = 16'h0000;
    end

    always @(posedge clock) begin
        held <= busIn;
        stall <= (readStrobeN && storeStrobeN) ? 0 : stall + 1;
        if (addrLatch) begin
            latched <= busOut[7:0];
        end
        if (!storeStrobeN) begin
            lastWr <= busOut;
        end
    end

    always @(negedge readStrobeN) rdCount++;
    always @(negedge storeStrobeN) wrCount++;
endmodule

// [testbench/eau_external_access_unit_tb_top.sv]
// Self-checking bench for the external access unit.
// Assumes eau_ext_mem as far side; hold requests driven from here.
`timescale 1ns/1ps
`include "eau_defs.svh"

module eau_external_access_unit_tb_top;
    import eau_pkg::*;

    typedef struct {logic [2:0] m; logic [1:0] s; logic [7:0] t; logic [23:0] a; logic w; logic b; int lat;} eau_row_s;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] bootMode = `EAU_MODE_MUX16;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqByte = 1'b0, cfgLoad = 1'b0, storePinConfig = 1'b0, slow = 1'b0;
    logic [23:0] reqAddr = 24'h0;
    logic [15:0] reqWdata = 16'h0, rd, busIn, sbOut, sbOeN, aoOut, lastWr;
    logic [2:0] cfgBusMode = 3'h0, busModeNow;
    logic [1:0] cfgSpace = 2'h3;
    logic [47:0] cfgTiming = 48'h0;
    logic [59:0] regionBase = 60'h0, regionMask = 60'h0;
    logic [4:0] regionEnable = 5'h0;
    logic [7:0] p6OpenDrain = 8'h00, p6In = 8'hff, p6Out, p6OeN, upOeN, upSeen;
    logic respDone, addrLatch, readStrobeN, storeStrobeN, strobeOeN, readyPin, csLow;
    int err_count = 0, checks_done = 0, rdCount, wrCount, n, c;
    eau_row_s r;
    eau_row_s rows[10] = '{
        '{`EAU_MODE_MUX16, `EAU_SPACE_16M, 8'h00, 24'h345670, 0, 0, 3},
        '{`EAU_MODE_DMX16, `EAU_SPACE_1M, 8'h00, 24'h0a1233, 0, 1, 3},
        '{`EAU_MODE_MUX8, `EAU_SPACE_256K, 8'h00, 24'h012344, 0, 0, 0},
        '{`EAU_MODE_DMX8, `EAU_SPACE_64K, 8'h01, 24'h001239, 1, 1, 0},
        '{`EAU_MODE_DMX16, `EAU_SPACE_16M, 8'h21, 24'h200002, 0, 0, 5},
        '{`EAU_MODE_MUX16, `EAU_SPACE_16M, 8'h50, 24'h100004, 0, 0, 5},
        '{`EAU_MODE_DMX16, `EAU_SPACE_16M, 8'h00, 24'h300006, 1, 0, 3},
        '{`EAU_MODE_SINGLE, `EAU_SPACE_16M, 8'h00, 24'h345670, 0, 0, 1},
        '{`EAU_MODE_MUX16, `EAU_SPACE_16M, 8'h00, 24'h00fe10, 0, 0, 1},
        '{`EAU_MODE_DMX16, `EAU_SPACE_16M, 8'h00, 24'h00f100, 1, 0, 1}};

    eau_external_access_unit i_eau_external_access_unit (.clock(clock), .rst_n(rst_n), .bootMode(bootMode),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqByte(reqByte), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .respDone(respDone), .respRdata(rd), .cfgLoad(cfgLoad), .cfgBusMode(cfgBusMode), .cfgSpace(cfgSpace),
        .storePinConfig(storePinConfig), .cfgTiming(cfgTiming), .regionBase(regionBase), .regionMask(regionMask),
        .regionEnable(regionEnable), .p6OpenDrain(p6OpenDrain), .busModeNow(busModeNow), .sharedBusPortIn(busIn),
        .sharedBusPortOut(sbOut), .sharedBusPortOeN(sbOeN), .addressOnlyPortOut(aoOut), .addressOnlyPortOeN(),
        .upperAddrOut(), .upperAddrOeN(upOeN), .addrLatch(addrLatch), .readStrobeN(readStrobeN),
        .storeStrobeN(storeStrobeN), .strobeOeN(strobeOeN), .readyPin(readyPin), .p6In(p6In), .p6Out(p6Out),
        .p6OeN(p6OeN));

    eau_ext_mem i_eau_ext_mem (.clock(clock), .muxed(busModeNow == 3'h2 || busModeNow == 3'h3),
        .wide(busModeNow == 3'h1 || busModeNow == 3'h2), .slow(slow), .busOut(sbOut), .addrOut(aoOut),
        .addrLatch(addrLatch), .readStrobeN(readStrobeN), .storeStrobeN(storeStrobeN), .busIn(busIn),
        .readyPin(readyPin), .rdCount(rdCount), .wrCount(wrCount), .lastWr(lastWr));

    ////////////////////////////////////////////////////////////////
    always #20 clock = ~clock;

    // Only written while a strobe is active, so the clear in acc never races it
    always @(posedge clock) begin
        if (!(readStrobeN && storeStrobeN)) begin
            upSeen <= upOeN;
            if (!p6OeN[0] && !p6Out[0]) begin
                csLow <= 1'b1;
            end
        end
    end

    function automatic logic [7:0] xb(input logic [23:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (exp !== got) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cfg(input logic [2:0] m, input logic [1:0] s, input logic [47:0] t, input logic sp);
        @(posedge clock);
        cfgLoad <= 1'b1;
        cfgBusMode <= m;
        cfgSpace <= s;
        cfgTiming <= t;
        storePinConfig <= sp;
        @(posedge clock);
        cfgLoad <= 1'b0;
    endtask

    task automatic acc(input logic [23:0] a, input logic w, input logic b);
        @(posedge clock);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqByte <= b;
        reqAddr <= a;
        reqWdata <= a[15:0];
        csLow <= 1'b0;
        n = 0;
        c = rdCount + wrCount;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (respDone !== 1'b1 && n < 300);
        chk("respDone", 1, respDone);
        @(posedge clock);
        reqValid <= 1'b0;
    endtask

    task summarize;
        $display("checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("boot mode", `EAU_MODE_MUX16, busModeNow);
        chk("p6 idle", 15'h107f, {p6OeN, p6Out[7:6], p6Out[4:0]});
        acc(24'h345670, 0, 0);
        chk("default latency", 21, n);
        foreach (rows[i]) begin
            r = rows[i];
            cfg(r.m, r.s, {r.t, 40'h0}, 1'b0);
            acc(r.a, r.w, r.b);
            if (r.lat > 0) chk("latency", r.lat, n);
            if (r.lat == 1) begin
                chk("internal strobes", c, rdCount + wrCount);
                if (!r.w) chk("internal data", 0, rd);
            end else begin
                chk("strobes", c + ((r.m[0] == r.m[1] || r.m[2]) && !r.b ? 2 : 1), rdCount + wrCount);
                chk("upper oe", r.s == 0 ? `EAU_UPPER_64K : r.s == 1 ? `EAU_UPPER_256K : r.s == 2 ?
                    `EAU_UPPER_1M : `EAU_UPPER_16M, upSeen);
                if (r.w) chk("wdata", r.b ? {8'h00, r.a[7:0]} : r.a[15:0], r.b ? {8'h00, lastWr[7:0]} : lastWr);
                else chk("rdata", r.b ? {8'h00, xb(r.a)} : {xb(r.a + 1), xb(r.a)}, r.b ? {8'h00, rd[7:0]} : rd);
            end
        end
        // Region 0 picks fast set 0 and its select, open drain
        regionBase <= 60'h345;
        regionMask <= 60'hfff;
        regionEnable <= 5'h01;
        p6OpenDrain <= 8'h01;
        cfg(`EAU_MODE_MUX16, `EAU_SPACE_16M, {8'h03, 40'h0}, 1'b0);
        acc(24'h345670, 0, 0);
        chk("region latency", {n, csLow}, {32'd3, 1'b1});
        acc(24'h346670, 0, 0);
        chk("outside latency", {n, csLow}, {32'd6, 1'b0});
        regionEnable <= 5'h00;
        p6OpenDrain <= 8'h00;
        cfg(`EAU_MODE_DMX16, `EAU_SPACE_16M, 48'h0, 1'b1);
        acc(24'h300007, 1, 1);
        chk("odd byte store", c, rdCount + wrCount);
        acc(24'h300006, 1, 1);
        chk("even byte store", c + 1, rdCount + wrCount);
        slow <= 1'b1;
        cfg(`EAU_MODE_MUX16, `EAU_SPACE_16M, {8'h80, 40'h0}, 1'b0);
        acc(24'h345670, 0, 0);
        chk("ready latency", 6, n);
        slow <= 1'b0;
        p6In <= 8'hdf;
        repeat (3) @(posedge clock);
        #1;
        chk("granted", {1'b0, 16'hffff, 1'b1}, {p6Out[6], sbOeN, strobeOeN});
        fork
            acc(24'h345670, 0, 0);
            begin
                repeat (5) @(posedge clock);
                #1;
                chk("regain request", 0, p6Out[7]);
                @(posedge clock);
                p6In <= 8'hff;
            end
        join
        chk("held off", 1, n > 6);
        bootMode <= `EAU_MODE_DMX8;
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("boot mode again", `EAU_MODE_DMX8, busModeNow);
        acc(24'h123457, 0, 1);
        chk("reset timing", {n, 8'h00, rd[7:0]}, {32'd21, 8'h00, xb(24'h123457)});
        summarize();
    end
endmodule
